// ---- rtl/psd_pkg.sv ----
// Constants for the peripheral space decoder.
// Assumes a 24-bit CPU address and 16-bit register data.
package psd_pkg;
    localparam logic [15:0] PSD_ENABLE_ADDR  = 16'hf024;
    localparam logic [7:0]  PSD_ENABLE_SHORT = 8'h12;
    localparam logic [15:0] PSD_ENABLE_RESET = 16'h0005;
    localparam logic [15:0] PSD_ENABLE_MASK  = 16'h07df;
    localparam int PSD_B_CAN1  = 0;
    localparam int PSD_B_CAN2  = 1;
    localparam int PSD_B_XRAM1 = 2;
    localparam int PSD_B_XRAM2 = 3;
    localparam int PSD_B_RTC   = 4;
    localparam int PSD_B_PWM   = 6;
    localparam int PSD_B_ASC   = 7;
    localparam int PSD_B_SSC   = 8;
    localparam int PSD_B_I2C   = 9;
    localparam int PSD_B_MISC  = 10;
    localparam int PSD_NWIN    = 10;
    // Window bases and ends, indexed as target selects
    localparam logic [23:0] PSD_CAN_LO   = 24'h00ec00;
    localparam logic [23:0] PSD_CAN_HI   = 24'h00efff;
    localparam logic [23:0] PSD_XRAM1_LO = 24'h00e000;
    localparam logic [23:0] PSD_XRAM1_HI = 24'h00e7ff;
    localparam logic [23:0] PSD_XRAM2_LO = 24'h0f0000;
    localparam logic [23:0] PSD_XRAM2_HI = 24'h0fffff;
    localparam logic [23:0] PSD_RTC_LO   = 24'h00ed00;
    localparam logic [23:0] PSD_RTC_HI   = 24'h00edff;
    localparam logic [23:0] PSD_PWM_LO   = 24'h00ec00;
    localparam logic [23:0] PSD_PWM_HI   = 24'h00ecff;
    localparam logic [23:0] PSD_ASC_LO   = 24'h00e900;
    localparam logic [23:0] PSD_ASC_HI   = 24'h00e9ff;
    localparam logic [23:0] PSD_SSC_LO   = 24'h00e800;
    localparam logic [23:0] PSD_SSC_HI   = 24'h00e8ff;
    localparam logic [23:0] PSD_I2C_LO   = 24'h00ea00;
    localparam logic [23:0] PSD_I2C_HI   = 24'h00eaff;
    localparam logic [23:0] PSD_MISC_LO  = 24'h00eb00;
    localparam logic [23:0] PSD_MISC_HI  = 24'h00ebff;
    localparam logic [23:0] PSD_SHARED_LO = 24'h00e800;
    localparam logic [23:0] PSD_SHARED_HI = 24'h00efff;
endpackage : psd_pkg

// ---- rtl/psd_window.sv ----
// One address window compare with enable gate.
// Assumes address and bounds in the same clock domain.
`timescale 1ns/10ps
module psd_window
    import psd_pkg::*;
#(
    parameter logic [23:0] LO = 24'h000000,
    parameter logic [23:0] HI = 24'h000000
)
(
    // Access
    input  wire logic [23:0] addr,
    input  wire logic        en,
    // Result
    output logic             hit,
    output logic             sel
);
    assign hit = (addr >= LO) && (addr <= HI);
    assign sel = hit && en;
endmodule : psd_window

// ---- rtl/psd_decoder.sv ----
// Enable register and address steering for the extension peripherals.
// Assumes a single-cycle CPU access strobe on SYS_CLK; outputs are
// registered, so each access's route appears one cycle after its strobe.
`timescale 1ns/10ps
module psd_decoder
    import psd_pkg::*;
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // Mode inputs from system configuration
    input  wire logic        GLOBAL_EXT_PERIPH_ENABLE,
    input  wire logic        EMULATION_MODE,
    // Register port (extended special register space)
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    output logic      [15:0] REG_RDATA,
    // CPU access to be steered
    input  wire logic        ACC_VALID,
    input  wire logic [23:0] ACC_ADDR,
    // Routes
    output logic             SEL_CAN1,
    output logic             SEL_CAN2,
    output logic             SEL_XRAM1,
    output logic             SEL_XRAM2,
    output logic             SEL_RTC,
    output logic             SEL_PWM,
    output logic             SEL_ASC,
    output logic             SEL_SSC,
    output logic             SEL_I2C,
    output logic             SEL_MISC,
    output logic             SEL_EXTERNAL,
    // Pin ownership, high where the pin is free as general I/O
    output logic      [10:0] PIN_GPIO_FREE
);

    logic [15:0] enable_reg;
    logic [15:0] enable_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [15:0] eff_en;
    logic        reg_hit;

    // Emulation overrides the effective enables, not the stored value itself
    assign eff_en  = EMULATION_MODE ? PSD_ENABLE_MASK : enable_reg;
    assign reg_hit = (REG_ADDR == PSD_ENABLE_ADDR);

    always_comb
    begin
        enable_next = enable_reg;
        if (REG_WR && reg_hit && !GLOBAL_EXT_PERIPH_ENABLE)
        begin
            // Reserved positions kept zero even if software slips
            enable_next = REG_WDATA & PSD_ENABLE_MASK;
        end
        rdata_next = rdata_reg;
        if (REG_RD)
        begin
            rdata_next = reg_hit ? eff_en : 16'h0000;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            enable_reg <= PSD_ENABLE_RESET;
            rdata_reg  <= 16'h0000;
        end
        else
        begin
            enable_reg <= enable_next;
            rdata_reg  <= rdata_next;
        end
    end
    assign REG_RDATA = rdata_reg;

    // Window compares, each gated by its effective enable
    logic [PSD_NWIN-1:0] hit;
    logic [PSD_NWIN-1:0] sel;
    logic [PSD_NWIN-1:0] win_en;
    assign win_en = {eff_en[PSD_B_MISC], eff_en[PSD_B_I2C],
                     eff_en[PSD_B_SSC],  eff_en[PSD_B_ASC],
                     eff_en[PSD_B_PWM],  eff_en[PSD_B_RTC],
                     eff_en[PSD_B_XRAM2], eff_en[PSD_B_XRAM1],
                     eff_en[PSD_B_CAN2], eff_en[PSD_B_CAN1]};

    psd_window #(.LO(PSD_CAN_LO), .HI(PSD_CAN_HI)) u_can1
    (
        .addr(ACC_ADDR), .en(win_en[0]), .hit(hit[0]), .sel(sel[0])
    );
    psd_window #(.LO(PSD_CAN_LO), .HI(PSD_CAN_HI)) u_can2
    (
        .addr(ACC_ADDR), .en(win_en[1]), .hit(hit[1]), .sel(sel[1])
    );
    psd_window #(.LO(PSD_XRAM1_LO), .HI(PSD_XRAM1_HI)) u_xram1
    (
        .addr(ACC_ADDR), .en(win_en[2]), .hit(hit[2]), .sel(sel[2])
    );
    psd_window #(.LO(PSD_XRAM2_LO), .HI(PSD_XRAM2_HI)) u_xram2
    (
        .addr(ACC_ADDR), .en(win_en[3]), .hit(hit[3]), .sel(sel[3])
    );
    psd_window #(.LO(PSD_RTC_LO), .HI(PSD_RTC_HI)) u_rtc
    (
        .addr(ACC_ADDR), .en(win_en[4]), .hit(hit[4]), .sel(sel[4])
    );
    psd_window #(.LO(PSD_PWM_LO), .HI(PSD_PWM_HI)) u_pwm
    (
        .addr(ACC_ADDR), .en(win_en[5]), .hit(hit[5]), .sel(sel[5])
    );
    psd_window #(.LO(PSD_ASC_LO), .HI(PSD_ASC_HI)) u_asc
    (
        .addr(ACC_ADDR), .en(win_en[6]), .hit(hit[6]), .sel(sel[6])
    );
    psd_window #(.LO(PSD_SSC_LO), .HI(PSD_SSC_HI)) u_ssc
    (
        .addr(ACC_ADDR), .en(win_en[7]), .hit(hit[7]), .sel(sel[7])
    );
    psd_window #(.LO(PSD_I2C_LO), .HI(PSD_I2C_HI)) u_i2c
    (
        .addr(ACC_ADDR), .en(win_en[8]), .hit(hit[8]), .sel(sel[8])
    );
    psd_window #(.LO(PSD_MISC_LO), .HI(PSD_MISC_HI)) u_misc
    (
        .addr(ACC_ADDR), .en(win_en[9]), .hit(hit[9]), .sel(sel[9])
    );

    // Shared range stays internal while any shared module is on, so a
    // hole inside it simply gets no answer rather than going off-chip.
    logic any_shared;
    logic in_shared;
    logic to_ext;
    assign any_shared = eff_en[PSD_B_CAN1] | eff_en[PSD_B_CAN2]
                      | eff_en[PSD_B_RTC]  | eff_en[PSD_B_PWM]
                      | eff_en[PSD_B_ASC]  | eff_en[PSD_B_SSC]
                      | eff_en[PSD_B_I2C]  | eff_en[PSD_B_MISC];
    assign in_shared  = (ACC_ADDR >= PSD_SHARED_LO)
                      && (ACC_ADDR <= PSD_SHARED_HI);
    always_comb
    begin
        to_ext = 1'b1;
        if (|sel)
        begin
            to_ext = 1'b0;
        end
        else if (in_shared && any_shared)
        begin
            to_ext = 1'b0;
        end
    end

    // Registered route strobes, fresh per access from live enables
    logic [PSD_NWIN-1:0] sel_reg;
    logic [PSD_NWIN-1:0] sel_next;
    logic                ext_reg;
    logic                ext_next;
    logic [10:0]         pins_reg;
    logic [10:0]         pins_next;

    always_comb
    begin
        sel_next  = ACC_VALID ? sel : '0;
        ext_next  = ACC_VALID && to_ext;
        pins_next = ~eff_en[10:0];
        pins_next[5] = 1'b0;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sel_reg  <= '0;
            ext_reg  <= 1'b0;
            pins_reg <= ~PSD_ENABLE_RESET[10:0] & PSD_ENABLE_MASK[10:0];
        end
        else
        begin
            sel_reg  <= sel_next;
            ext_reg  <= ext_next;
            pins_reg <= pins_next;
        end
    end

    assign SEL_CAN1      = sel_reg[0];
    assign SEL_CAN2      = sel_reg[1];
    assign SEL_XRAM1     = sel_reg[2];
    assign SEL_XRAM2     = sel_reg[3];
    assign SEL_RTC       = sel_reg[4];
    assign SEL_PWM       = sel_reg[5];
    assign SEL_ASC       = sel_reg[6];
    assign SEL_SSC       = sel_reg[7];
    assign SEL_I2C       = sel_reg[8];
    assign SEL_MISC      = sel_reg[9];
    assign SEL_EXTERNAL  = ext_reg;
    assign PIN_GPIO_FREE = pins_reg;

    // Register checks
    reset_value_a: assert property (@(posedge SYS_CLK)
        $rose(RST_N) |-> enable_reg == PSD_ENABLE_RESET)
        else $error("enable register not at reset value");
    frozen_reg_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        GLOBAL_EXT_PERIPH_ENABLE |=> $stable(enable_reg))
        else $error("enable register changed while frozen");
    emul_force_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        EMULATION_MODE && REG_RD && reg_hit |=> REG_RDATA == PSD_ENABLE_MASK)
        else $error("emulation did not force enables");
    reserved_zero_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N) (enable_reg & ~PSD_ENABLE_MASK) == 16'h0000)
        else $error("reserved bits set");
    write_live_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N) REG_WR && reg_hit && !GLOBAL_EXT_PERIPH_ENABLE
        |=> enable_reg == ($past(REG_WDATA) & PSD_ENABLE_MASK))
        else $error("permitted write lost");

    // Routing checks
    can1_off_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N) !eff_en[PSD_B_CAN1] |=> !SEL_CAN1)
        else $error("disabled first CAN selected");
    xram1_ext_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N) ACC_VALID && hit[2] && !eff_en[PSD_B_XRAM1]
        |=> SEL_EXTERNAL && !SEL_XRAM1)
        else $error("small RAM window not external");
    xram2_ext_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N) ACC_VALID && hit[3] && !eff_en[PSD_B_XRAM2]
        |=> SEL_EXTERNAL && !SEL_XRAM2)
        else $error("large RAM window not external");
    shared_hold_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N) ACC_VALID && hit[4] && !eff_en[PSD_B_RTC]
        && any_shared |=> !SEL_EXTERNAL && !SEL_RTC)
        else $error("RTC window wrongly routed");
    // External only when no shared module is on at the access edge
    pwm_route_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N) ACC_VALID && hit[5] && !eff_en[PSD_B_PWM]
        |=> !SEL_PWM && (SEL_EXTERNAL != $past(any_shared)))
        else $error("PWM window wrongly routed");
    asc_route_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N) ACC_VALID && hit[6] && !eff_en[PSD_B_ASC]
        |=> !SEL_ASC && (SEL_EXTERNAL != $past(any_shared)))
        else $error("async serial window wrongly routed");
    ssc_route_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N) ACC_VALID && hit[7] && !eff_en[PSD_B_SSC]
        |=> !SEL_SSC && (SEL_EXTERNAL != $past(any_shared)))
        else $error("sync serial window wrongly routed");
    i2c_route_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N) ACC_VALID && hit[8] && !eff_en[PSD_B_I2C]
        |=> !SEL_I2C && (SEL_EXTERNAL != $past(any_shared)))
        else $error("I2C window wrongly routed");
    misc_route_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N) ACC_VALID && hit[9] && !eff_en[PSD_B_MISC]
        |=> !SEL_MISC && (SEL_EXTERNAL != $past(any_shared)))
        else $error("misc features window wrongly routed");
    shared_ext_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        ACC_VALID && in_shared && !any_shared |=> SEL_EXTERNAL)
        else $error("shared range not external");
    emul_sel_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N) EMULATION_MODE && ACC_VALID && hit[8] |=> SEL_I2C)
        else $error("emulation did not enable I2C");

    // Pin ownership checks
    can1_pins_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        eff_en[PSD_B_CAN1] |=> !PIN_GPIO_FREE[PSD_B_CAN1])
        else $error("enabled first CAN pins left free");
    can2_pins_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        !eff_en[PSD_B_CAN2] |=> PIN_GPIO_FREE[PSD_B_CAN2])
        else $error("second CAN pins not freed");
    i2c_pins_a: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        !eff_en[PSD_B_I2C] |=> PIN_GPIO_FREE[PSD_B_I2C])
        else $error("I2C pins not freed");

    // Scenario coverage
    ext_cov_c: cover property (@(posedge SYS_CLK) SEL_EXTERNAL);
    can1_cov_c: cover property (@(posedge SYS_CLK) SEL_CAN1);
    frozen_cov_c: cover property (@(posedge SYS_CLK)
        GLOBAL_EXT_PERIPH_ENABLE && REG_WR && reg_hit);
    emul_cov_c: cover property (@(posedge SYS_CLK)
        EMULATION_MODE && SEL_XRAM2);
    shared_cov_c: cover property (@(posedge SYS_CLK)
        ACC_VALID && in_shared && !any_shared);

endmodule : psd_decoder

// ---- bench/psd_far_side.sv ----
// Far-side model: peripherals and external bus answering routed accesses.
// Assumes one select pulse per access, registered on the decoder clock.
`timescale 1ns/10ps
module psd_far_side (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Selects, external bus in bit 10
    input  wire logic [10:0] sel,
    // Observed route and external cycle count
    output logic      [10:0] route,
    output logic      [7:0]  ext_count
);
    assign route = sel;
    // External bus only counts; its configuration is chosen elsewhere
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ext_count <= 8'h00;
        else if (sel[10])
            ext_count <= ext_count + 8'h01;
    end
endmodule : psd_far_side

// ---- bench/peripheral_space_decoder_test.sv ----
// Self-checking bench for the peripheral space decoder.
// Assumes the far-side model in psd_far_side and the package constants.
`timescale 1ns/10ps
`define CHK(a, b) check_count++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end
module peripheral_space_decoder_test;
    import psd_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        gpe = 1'b0;
    logic        emu = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic        acc_valid = 1'b0;
    logic [23:0] acc_addr = 24'h000000;
    wire  [10:0] sel_vec;
    logic [10:0] route;
    logic [10:0] gpio_free;
    logic [7:0]  ext_count;
    logic [7:0]  ext_exp = 8'h00;
    int          errors = 0;
    int          check_count = 0;

    always #5 clk = ~clk;

    psd_decoder dut (
        .SYS_CLK(clk), .RST_N(rst_n),
        .GLOBAL_EXT_PERIPH_ENABLE(gpe), .EMULATION_MODE(emu),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .ACC_VALID(acc_valid), .ACC_ADDR(acc_addr),
        .SEL_CAN1(sel_vec[0]), .SEL_CAN2(sel_vec[1]),
        .SEL_XRAM1(sel_vec[2]), .SEL_XRAM2(sel_vec[3]),
        .SEL_RTC(sel_vec[4]), .SEL_PWM(sel_vec[5]), .SEL_ASC(sel_vec[6]),
        .SEL_SSC(sel_vec[7]), .SEL_I2C(sel_vec[8]), .SEL_MISC(sel_vec[9]),
        .SEL_EXTERNAL(sel_vec[10]), .PIN_GPIO_FREE(gpio_free)
    );

    psd_far_side far (
        .clk(clk), .rst_n(rst_n), .sel(sel_vec),
        .route(route), .ext_count(ext_count)
    );

    task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, exp)
    endtask : reg_read

    // Route shows one cycle after the strobe edge, for one cycle only
    task automatic access(input logic [23:0] a, input logic [10:0] exp);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_addr <= a;
        @(posedge clk);
        acc_valid <= 1'b0;
        #1;
        `CHK(route, exp)
        if (exp[10])
            ext_exp++;
    endtask : access

    task automatic test_reset_state;
        reg_read(PSD_ENABLE_ADDR, 16'h0005);
        reg_read(16'hf026, 16'h0000);
        `CHK(gpio_free, 11'h7da)
        access(24'h00e100, 11'h004);
        access(24'h0f0000, 11'h400);
        access(24'h00ec00, 11'h001);
        access(24'h00ed00, 11'h001);
        access(24'h00e800, 11'h000);
        access(24'h00e900, 11'h000);
        access(24'h00ea00, 11'h000);
        access(24'h00eb00, 11'h000);
    endtask : test_reset_state

    task automatic test_all_off;
        reg_write(PSD_ENABLE_ADDR, 16'h0000);
        access(24'h00e800, 11'h400);
        access(24'h00ed00, 11'h400);
        access(24'h00ec00, 11'h400);
        access(24'h00e100, 11'h400);
        `CHK(gpio_free, 11'h7df)
        // Far side counts one edge after the route shows
        @(posedge clk);
        #1;
        `CHK(ext_count, ext_exp)
    endtask : test_all_off

    task automatic test_all_on;
        reg_write(PSD_ENABLE_ADDR, 16'h07df);
        access(24'h00ec00, 11'h023);
        access(24'h00e800, 11'h080);
        access(24'h00e900, 11'h040);
        access(24'h00eb00, 11'h200);
        access(24'h0f1234, 11'h008);
        `CHK(gpio_free, 11'h000)
        reg_write(PSD_ENABLE_ADDR, 16'h0002);
        access(24'h00ee00, 11'h002);
    endtask : test_all_on

    task automatic test_freeze;
        @(posedge clk);
        gpe <= 1'b1;
        reg_write(PSD_ENABLE_ADDR, 16'h0100);
        reg_read(PSD_ENABLE_ADDR, 16'h0002);
        access(24'h00ea00, 11'h000);
    endtask : test_freeze

    task automatic test_emulation;
        @(posedge clk);
        emu <= 1'b1;
        reg_read(PSD_ENABLE_ADDR, 16'h07df);
        access(24'h00ea00, 11'h100);
        access(24'h00ed00, 11'h013);
        access(24'h0f0000, 11'h008);
        `CHK(gpio_free, 11'h000)
        @(posedge clk);
        emu <= 1'b0;
        reg_read(PSD_ENABLE_ADDR, 16'h0002);
        `CHK(gpio_free, 11'h7dd)
    endtask : test_emulation

    task automatic end_sim;
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        test_reset_state();
        test_all_off();
        test_all_on();
        test_freeze();
        test_emulation();
        end_sim();
    end

    initial
    begin
        repeat (2000) @(posedge clk);
        errors++;
        end_sim();
    end
endmodule : peripheral_space_decoder_test
